// file: verilog/cvid_pkg.sv
`default_nettype none
package cvid_pkg;
   // ---------------------------------------------------------------
   // access geometry
   // ---------------------------------------------------------------
   localparam int CVID_ADDR_W = 16;
   localparam int CVID_DATA_W = 8;
   // byte offsets of the identification registers
   localparam logic [15:0] CVID_OFS_MAJOR = 16'h0001;
   localparam logic [15:0] CVID_OFS_BUILD_LO = 16'h0002;
   localparam logic [15:0] CVID_OFS_BUILD_HI = 16'h0003;
   // field positions inside the 16-bit build register
   localparam int CVID_MAINT_LSB = 0;
   localparam int CVID_MINOR_LSB = 4;
   localparam int CVID_PATCH_LSB = 8;
   // patch level encoding
   localparam logic [7:0] CVID_PATCH_ORIGINAL = 8'h00;
   localparam logic [7:0] CVID_PATCH_MAX = 8'h0F;
   // maintenance letter base: ascii 'a' encodes as zero
   localparam logic [7:0] CVID_LETTER_BASE = 8'h61;
   // answer for any byte this bank does not own
   localparam logic [7:0] CVID_UNMAPPED_DATA = 8'h00;
   // ---------------------------------------------------------------
   // evaluation time limit
   // ---------------------------------------------------------------
   localparam longint CVID_CLK_HZ = 125000000;
   localparam longint CVID_EVAL_LIMIT_S = 3600;
   localparam int CVID_EVAL_CNT_W = 40;
   localparam logic [39:0] CVID_EVAL_LIMIT_CYC = 40'(CVID_EVAL_LIMIT_S * CVID_CLK_HZ);
   // read-port states
   typedef enum logic [0:0] {
      CVID_PORT_IDLE = 1'b0,
      CVID_PORT_ANSWER = 1'b1
   } cvid_port_state_t;

   // ascii letter to binary maintenance code
   function automatic logic [3:0] cvid_letter_code(input logic [7:0] letter);
      logic [7:0] diff;
      diff = letter - CVID_LETTER_BASE;
      return diff[3:0];
   endfunction : cvid_letter_code

   // byte select over the bank; shared by both access ports
   function automatic logic [8:0] cvid_decode(input logic [15:0] addr, input logic [7:0] major,
                                              input logic [15:0] build);
      // bit 8 is the hit flag, bits 7:0 the byte
      case (addr)
         CVID_OFS_MAJOR: return {1'b1, major};
         CVID_OFS_BUILD_LO: return {1'b1, build[7:0]};
         CVID_OFS_BUILD_HI: return {1'b1, build[15:8]};
         default: return {1'b0, CVID_UNMAPPED_DATA};
      endcase
   endfunction : cvid_decode
endpackage : cvid_pkg
`default_nettype wire

// file: verilog/cvid_read_port.sv
`timescale 1ns/1ns
`default_nettype none
module cvid_read_port import cvid_pkg::*; (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic ce,
   input wire logic halted,
   input wire logic rd_en,
   input wire logic wr_en,
   input wire logic [CVID_ADDR_W-1:0] addr,
   input wire logic [CVID_DATA_W-1:0] wdata,
   input wire logic [7:0] major,
   input wire logic [15:0] build,
   output logic [CVID_DATA_W-1:0] rdata,
   output logic rvalid,
   output logic hit
);
   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   cvid_port_state_t state;
   cvid_port_state_t next_state;
   wire logic [8:0] sel = cvid_decode(addr, major, build);
   // a halted core answers nothing; writes never reach the bank
   wire logic take_rd = ce & rd_en & ~halted;
   wire logic unused_wr = wr_en ^ (^wdata);

   always_comb begin
      case (state)
         CVID_PORT_IDLE: next_state = take_rd ? CVID_PORT_ANSWER : CVID_PORT_IDLE;
         CVID_PORT_ANSWER: next_state = take_rd ? CVID_PORT_ANSWER : CVID_PORT_IDLE;
         default: next_state = CVID_PORT_IDLE;
      endcase
   end

   // ---------------------------------------------------------------
   // answer registers
   // ---------------------------------------------------------------
   // data holds until the next read so a slow master can sample late
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state <= CVID_PORT_IDLE;
         rdata <= CVID_UNMAPPED_DATA;
         rvalid <= 1'b0;
         hit <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         rvalid <= take_rd;
         if (take_rd) begin
            rdata <= sel[7:0];
            hit <= sel[8];
         end
      end
   end
endmodule : cvid_read_port
`default_nettype wire

// file: verilog/cvid_regs.sv
`timescale 1ns/1ns
`default_nettype none
module cvid_regs import cvid_pkg::*; #(
   parameter logic [7:0] VER_MAJOR = 8'h01,
   parameter logic [3:0] VER_MINOR = 4'h0,
   parameter logic [7:0] VER_MAINT_LETTER = 8'h61,
   parameter logic [7:0] VER_PATCH = 8'h00,
   parameter bit EVAL_BUILD = 1'b0,
   parameter logic [CVID_EVAL_CNT_W-1:0] EVAL_LIMIT_CYCLES = CVID_EVAL_LIMIT_CYC
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic ce,
   input wire logic net_rd_en,
   input wire logic net_wr_en,
   input wire logic [CVID_ADDR_W-1:0] net_addr,
   input wire logic [CVID_DATA_W-1:0] net_wdata,
   output logic [CVID_DATA_W-1:0] net_rdata,
   output logic net_rvalid,
   output logic net_hit,
   input wire logic host_rd_en,
   input wire logic host_wr_en,
   input wire logic [CVID_ADDR_W-1:0] host_addr,
   input wire logic [CVID_DATA_W-1:0] host_wdata,
   output logic [CVID_DATA_W-1:0] host_rdata,
   output logic host_rvalid,
   output logic host_hit,
   output logic core_run
);
   // ---------------------------------------------------------------
   // fixed register contents
   // ---------------------------------------------------------------
   // patch levels above the documented range are clipped at build time
   localparam logic [7:0] PATCH_USED = (VER_PATCH > CVID_PATCH_MAX) ? CVID_PATCH_MAX : VER_PATCH;
   localparam logic [3:0] MAINT_CODE = cvid_letter_code(VER_MAINT_LETTER);

   // wires, not flops: nothing can write them and reset cannot touch them
   wire logic [7:0] major_reg = VER_MAJOR;
   wire logic [15:0] build_reg = {PATCH_USED, VER_MINOR, MAINT_CODE};

   // ---------------------------------------------------------------
   // evaluation timer
   // ---------------------------------------------------------------
   logic [CVID_EVAL_CNT_W-1:0] run_cnt;
   wire logic limit_hit = (run_cnt == EVAL_LIMIT_CYCLES);
   wire logic [CVID_EVAL_CNT_W-1:0] next_run_cnt = limit_hit ? run_cnt : run_cnt + 40'h00_0000_0001;

   // counter saturates so the halt cannot wrap back to running
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         run_cnt <= '0;
         core_run <= 1'b1;
      end else if (ce && EVAL_BUILD) begin
         run_cnt <= next_run_cnt;
         if (limit_hit) begin
            core_run <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // two access ports
   // ---------------------------------------------------------------
   // same decode on both sides; writes are dropped inside the port
   cvid_read_port u_net_port (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .ce(ce),
      .halted(~core_run),
      .rd_en(net_rd_en),
      .wr_en(net_wr_en),
      .addr(net_addr),
      .wdata(net_wdata),
      .major(major_reg),
      .build(build_reg),
      .rdata(net_rdata),
      .rvalid(net_rvalid),
      .hit(net_hit)
   );

   cvid_read_port u_host_port (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .ce(ce),
      .halted(~core_run),
      .rd_en(host_rd_en),
      .wr_en(host_wr_en),
      .addr(host_addr),
      .wdata(host_wdata),
      .major(major_reg),
      .build(build_reg),
      .rdata(host_rdata),
      .rvalid(host_rvalid),
      .hit(host_hit)
   );

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   wire logic net_rd = ce & net_rd_en & core_run;
   wire logic host_rd = ce & host_rd_en & core_run;
   localparam logic [3:0] LETTER_EXP = 4'(VER_MAINT_LETTER - CVID_LETTER_BASE);

   property p_major;
      @(posedge clk_sys) disable iff (!resetn)
      (net_rd || host_rd) && (net_rd ? net_addr : host_addr) == CVID_OFS_MAJOR |=>
         (net_rvalid || host_rvalid) && (net_rvalid ? net_rdata : host_rdata) == VER_MAJOR;
   endproperty
   a_major: assert property (p_major) else $error("major version byte wrong");

   property p_maint;
      @(posedge clk_sys) disable iff (!resetn)
      net_rd && net_addr == CVID_OFS_BUILD_LO |=> net_rvalid && net_hit && net_rdata[3:0] == MAINT_CODE;
   endproperty
   a_maint: assert property (p_maint) else $error("maintenance nibble wrong");

   property p_minor;
      @(posedge clk_sys) disable iff (!resetn)
      host_rd && host_addr == CVID_OFS_BUILD_LO |=> host_rvalid && host_rdata[7:4] == VER_MINOR;
   endproperty
   a_minor: assert property (p_minor) else $error("minor version nibble wrong");

   property p_patch;
      @(posedge clk_sys) disable iff (!resetn)
      host_rd && host_addr == CVID_OFS_BUILD_HI |=> host_rvalid && host_rdata <= CVID_PATCH_MAX;
   endproperty
   a_patch: assert property (p_patch) else $error("patch level out of range");

   property p_letter;
      @(posedge clk_sys) disable iff (!resetn)
      host_rd && host_addr == CVID_OFS_BUILD_LO |=> host_rdata[3:0] == LETTER_EXP;
   endproperty
   a_letter: assert property (p_letter) else $error("letter encoding wrong");

   property p_halt;
      @(posedge clk_sys) disable iff (!resetn)
      ce && limit_hit && EVAL_BUILD |=> !core_run ##1 !core_run;
   endproperty
   a_halt: assert property (p_halt) else $error("evaluation core still running");

   property p_full_runs;
      @(posedge clk_sys) disable iff (!resetn)
      !EVAL_BUILD |-> core_run && run_cnt == '0;
   endproperty
   a_full_runs: assert property (p_full_runs) else $error("full build stopped");

   property p_write_ignored;
      @(posedge clk_sys) disable iff (!resetn)
      ce && net_wr_en && !net_rd_en && net_addr == CVID_OFS_MAJOR ##1 net_rd && net_addr == CVID_OFS_MAJOR |=>
         net_rdata == VER_MAJOR;
   endproperty
   a_write_ignored: assert property (p_write_ignored) else $error("write changed register");

   property p_no_write_answer;
      @(posedge clk_sys) disable iff (!resetn)
      ce && host_wr_en && !host_rd_en |=> !host_rvalid;
   endproperty
   a_no_write_answer: assert property (p_no_write_answer) else $error("write produced an answer");

   c_net_major: cover property (@(posedge clk_sys) disable iff (!resetn) net_rd && net_addr == CVID_OFS_MAJOR);
   c_host_build: cover property (@(posedge clk_sys) disable iff (!resetn)
      host_rd && host_addr == CVID_OFS_BUILD_HI ##1 host_rvalid);
   c_both_read: cover property (@(posedge clk_sys) disable iff (!resetn) net_rd && host_rd);
   c_halt: cover property (@(posedge clk_sys) disable iff (!resetn) $fell(core_run));
endmodule : cvid_regs
`default_nettype wire

// file: testbench/cvid_regs_bench.sv
`timescale 1ns/1ns
`default_nettype none
module cvid_regs_bench import cvid_pkg::*;;
   // ----------------------------------------------------------
   // build constants and bench state
   // ----------------------------------------------------------
   localparam logic [7:0] MAJ = 8'h3C;
   localparam logic [3:0] MIN = 4'h7;
   localparam logic [7:0] LET = 8'h63; // letter c
   localparam logic [7:0] PAT = 8'h0F; // highest patch level
   localparam int LIMIT = 200; // short limit keeps the run brief
   logic clk_sys, resetn, ce, core_run;
   logic rd [2];
   logic wr [2];
   logic [15:0] ad [2];
   logic [7:0] wd [2];
   logic [7:0] rdata [2];
   logic rvalid [2];
   logic hit [2];
   logic [8:0] q [2][$];
   logic [8:0] last [2];
   logic exp_rv [2];
   logic ce_last;
   bit [1:0] fresh;
   int n_fail, n_tests, seed, cnt;

   cvid_regs #(.VER_MAJOR(MAJ), .VER_MINOR(MIN), .VER_MAINT_LETTER(LET), .VER_PATCH(PAT),
      .EVAL_BUILD(1'b1), .EVAL_LIMIT_CYCLES(40'(LIMIT))) dut (
      .clk_sys(clk_sys), .resetn(resetn), .ce(ce),
      .net_rd_en(rd[0]), .net_wr_en(wr[0]), .net_addr(ad[0]), .net_wdata(wd[0]),
      .net_rdata(rdata[0]), .net_rvalid(rvalid[0]), .net_hit(hit[0]),
      .host_rd_en(rd[1]), .host_wr_en(wr[1]), .host_addr(ad[1]), .host_wdata(wd[1]),
      .host_rdata(rdata[1]), .host_rvalid(rvalid[1]), .host_hit(hit[1]),
      .core_run(core_run));

   // starts high so no falling edge fires before reset is applied
   initial begin
      clk_sys = 1'b1;
      forever #4 clk_sys = ~clk_sys;
   end

   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   task automatic check(input string what, input logic [8:0] e, input logic [8:0] s);
      n_tests++;
      if (s !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, e, s);
      end
   endtask : check

   // hit flag and byte expected for one address
   function automatic logic [8:0] expect_of(input logic [15:0] a);
      logic [3:0] maint;
      maint = 4'(LET - 8'h61);
      case (a)
         16'h0001: return {1'b1, MAJ};
         16'h0002: return {1'b1, MIN, maint};
         16'h0003: return {1'b1, PAT};
         default: return 9'h000;
      endcase
   endfunction : expect_of

   // one cycle of stimulus; a taken read is noted in its queue
   task automatic drive(input bit rnd);
      int sel;
      @(posedge clk_sys);
      #1;
      ce = rnd ? (({$random(seed)} % 8) != 0) : 1'b1;
      for (int p = 0; p < 2; p++) begin
         sel = {$random(seed)} % 6;
         rd[p] = rnd & 1'($random(seed));
         wr[p] = rnd & 1'($random(seed)); // writes must leave bytes alone
         ad[p] = (sel < 4) ? 16'(sel) : 16'($random(seed));
         wd[p] = 8'($random(seed));
         fresh[p] = resetn && ce && rd[p] && (core_run === 1'b1);
         if (fresh[p]) begin
            q[p].push_back(expect_of(ad[p]));
         end
      end
   endtask : drive

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : give_verdict

   // ----------------------------------------------------------
   // enabled-edge count, the yardstick for the time limit
   // ----------------------------------------------------------
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cnt <= 0;
      end else if (ce) begin
         cnt <= cnt + 1;
      end
   end

   // ce as the design saw it; a frozen edge leaves rvalid as it stood
   always @(posedge clk_sys) begin
      ce_last <= ce;
   end

   // ----------------------------------------------------------
   // monitor: oldest note against each answer, held bytes otherwise
   // ----------------------------------------------------------
   always @(negedge clk_sys) begin
      if (!resetn) begin
         for (int p = 0; p < 2; p++) begin
            check("reset byte", 9'h000, {hit[p], rdata[p]});
            check("reset rvalid", 9'h000, {8'h00, rvalid[p]});
            q[p].delete();
            last[p] = 9'h000;
            exp_rv[p] = 1'b0;
         end
         check("reset core_run", 9'h001, {8'h00, core_run});
      end else begin
         for (int p = 0; p < 2; p++) begin
            // a read noted this cycle is answered only after the next edge
            if (ce_last === 1'b1) begin
               exp_rv[p] = q[p].size() > int'(fresh[p]);
            end
            check("rvalid", {8'h00, exp_rv[p]}, {8'h00, rvalid[p]});
            if (ce_last === 1'b1 && exp_rv[p] === 1'b1) begin
               last[p] = q[p].pop_front();
            end
            check("read byte", last[p], {hit[p], rdata[p]});
         end
         // halt lands on the enabled edge after the counter reaches the limit
         if (cnt <= LIMIT) begin
            check("core_run high", 9'h001, {8'h00, core_run});
         end else begin
            check("core_run low", 9'h000, {8'h00, core_run});
         end
      end
   end

   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial begin
      seed = 74;
      resetn = 1'b0;
      ce = 1'b0;
      fresh = 2'b00;
      for (int p = 0; p < 2; p++) begin
         rd[p] = 1'b0;
         wr[p] = 1'b0;
         ad[p] = 16'h0000;
         wd[p] = 8'h00;
      end
      repeat (4) @(posedge clk_sys);
      #1;
      resetn = 1'b1;
      // random reads and writes on both ports, ce toggling
      repeat (150) drive(1'b1);
      // run on to the time limit under a bounded wait
      for (int i = 0; i < 3 * LIMIT; i++) begin
         drive(1'b1);
         if (core_run === 1'b0) begin
            break;
         end
      end
      // a used-up bound shows here as a mismatch and skips to the report
      check("limit reached", 9'h000, {8'h00, core_run});
      if (core_run === 1'b0) begin
         // halted core must refuse every read
         repeat (30) drive(1'b1);
         // reset mid-run restores the core; contents stay the same
         @(posedge clk_sys);
         #1;
         resetn = 1'b0;
         repeat (4) drive(1'b0);
         resetn = 1'b1;
         repeat (80) drive(1'b1);
         repeat (2) drive(1'b0);
      end
      give_verdict();
   end
endmodule : cvid_regs_bench
`default_nettype wire
